// ==== src/clr_exec.sv ====
// file-clear and watchdog-restart instruction execution with apb access
//
// The address map and the APB register port were decided locally.
module clr_exec #(
  parameter int cnt_w = 16,
  parameter int post_w = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wdt_tick,
  output logic [cnt_w-1:0] watchdog_counter,
  output logic [post_w-1:0] wdt_post,
  output logic timeout_status_n,
  output logic powerdown_status_n,
  output logic file_we,
  output logic [11:0] file_addr,
  output logic [7:0] file_wdata,
  output logic busy
);
  // ==========================================================
  // state
  // configuration written over the bus
  logic ext_q, ext_d;
  logic [3:0] bank_select_register, bank_d;
  logic [11:0] fsr2_q, fsr2_d;

  // instruction sequencer
  logic [15:0] instr_q, instr_d;
  logic pend_q, pend_d;
  clr_exec_pkg::phase_e ph_q, ph_d;
  logic we_q, we_d;
  logic [11:0] addr_q, addr_d;
  logic [11:0] addr_r_q, addr_r_d;
  logic [15:0] done_q, done_d;

  // status flags, watchdog and read data
  logic [4:0] status_q, status_d;
  logic [cnt_w-1:0] cnt_q, cnt_d;
  logic [post_w-1:0] post_q, post_d;
  logic [31:0] rdata_q, rdata_d;

  // decode and strobes shared between the groups
  logic is_file_clear, is_watchdog_restart, bank_bit;
  logic [7:0] f_field;
  logic wr_acc, rd_setup, instr_wr;
  logic use_indexed;
  logic wd_clear, zero_set;

  // ==========================================================
  // decode of the latched instruction word
  assign f_field = instr_q[7:0];
  assign bank_bit = instr_q[clr_exec_pkg::bank_bit_pos];
  assign is_file_clear = (instr_q & clr_exec_pkg::file_clear_mask)
    == clr_exec_pkg::file_clear_code;
  assign is_watchdog_restart = instr_q == clr_exec_pkg::watchdog_restart_code;
  assign use_indexed = ext_q && (f_field <= clr_exec_pkg::indexed_limit);

  // ==========================================================
  // apb: zero wait states while running; a frozen block holds
  // pready low so that no write is acknowledged and then lost
  // pslverr is never raised: unmapped access is harmless
  assign wr_acc = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign instr_wr = wr_acc && (paddr == clr_exec_pkg::instr_off) && !pend_q;
  assign pready = clk_en;
  assign pslverr = 1'b0;
  assign prdata = rdata_q;

  // ==========================================================
  // phase strobes for the status and watchdog groups
  // restart acts in process phase
  assign wd_clear = pend_q && (ph_q == clr_exec_pkg::ph_process)
    && is_watchdog_restart;
  assign zero_set = pend_q && (ph_q == clr_exec_pkg::ph_write)
    && is_file_clear;

  // ==========================================================
  // configuration group; unmapped writes are ignored
  always_comb begin
    ext_d = ext_q;
    bank_d = bank_select_register;
    fsr2_d = fsr2_q;
    // extended mode, bank and indexed base
    if (wr_acc) begin
      unique case (paddr)
        clr_exec_pkg::ctrl_off: ext_d = pwdata[0];
        clr_exec_pkg::bank_off: bank_d = pwdata[3:0];
        clr_exec_pkg::fsr2_off: fsr2_d = pwdata[11:0];
        default: ;
      endcase
    end
  end

  // configuration registers, frozen while clk_en is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_q <= 1'b0;
      bank_select_register <= 4'h0;
      fsr2_q <= 12'h000;
    end else if (clk_en) begin
      ext_q <= ext_d;
      bank_select_register <= bank_d;
      fsr2_q <= fsr2_d;
    end
  end

  // ==========================================================
  // instruction sequencer: decode, read, process, write
  // one four-phase cycle
  always_comb begin
    instr_d = instr_q;
    pend_d = pend_q;
    ph_d = ph_q;
    we_d = 1'b0;
    addr_d = addr_q;
    addr_r_d = addr_r_q;
    done_d = done_q;
    // a word written while busy is dropped, not queued
    if (instr_wr) begin
      instr_d = pwdata[15:0];
      pend_d = 1'b1;
      ph_d = clr_exec_pkg::ph_decode;
    end
    if (pend_q) begin
      unique case (ph_q)
        clr_exec_pkg::ph_decode: begin
          // the word is already latched; nothing to fetch
          ph_d = clr_exec_pkg::ph_read;
        end
        clr_exec_pkg::ph_read: begin
          ph_d = clr_exec_pkg::ph_process;
          if (is_file_clear) begin
            if (bank_bit) begin
              addr_r_d = {bank_select_register, f_field};
            end else if (use_indexed) begin
              addr_r_d = fsr2_q + {4'h0, f_field};
            end else if (f_field < clr_exec_pkg::access_split) begin
              addr_r_d = {4'h0, f_field};
            end else begin
              addr_r_d = {clr_exec_pkg::access_high_bank, f_field};
            end
          end
        end
        clr_exec_pkg::ph_process: begin
          // the watchdog and status groups act on wd_clear here
          ph_d = clr_exec_pkg::ph_write;
        end
        clr_exec_pkg::ph_write: begin
          // a restart only frees the sequencer and counts in done_q here
          ph_d = clr_exec_pkg::ph_decode;
          pend_d = 1'b0;
          done_d = done_q + 1'b1;
          if (is_file_clear) begin
            we_d = 1'b1;
            addr_d = addr_r_q;
          end
        end
      endcase
    end
  end

  // sequencer registers; file_we stays one cycle unless frozen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_q <= 16'h0000;
      pend_q <= 1'b0;
      ph_q <= clr_exec_pkg::ph_decode;
      we_q <= 1'b0;
      addr_q <= 12'h000;
      addr_r_q <= 12'h000;
      done_q <= 16'h0000;
    end else if (clk_en) begin
      instr_q <= instr_d;
      pend_q <= pend_d;
      ph_q <= ph_d;
      we_q <= we_d;
      addr_q <= addr_d;
      addr_r_q <= addr_r_d;
      done_q <= done_d;
    end
  end

  // ==========================================================
  // status flags: a hardware set wins over a software write
  always_comb begin
    status_d = status_q;
    // software may clear or set any flag
    if (wr_acc && (paddr == clr_exec_pkg::status_off)) begin
      status_d = pwdata[4:0];
    end
    if (zero_set) begin
      status_d[clr_exec_pkg::zero_pos] = 1'b1;
    end
    if (wd_clear) begin
      status_d[clr_exec_pkg::timeout_pos] = 1'b1;
      status_d[clr_exec_pkg::powerdown_pos] = 1'b1;
    end
  end

  // status register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= clr_exec_pkg::status_rst;
    end else if (clk_en) begin
      status_q <= status_d;
    end
  end

  // ==========================================================
  // watchdog: postscaler wraps into the counter
  // the counter width sets how long a lapse may run unnoticed
  always_comb begin
    cnt_d = cnt_q;
    post_d = post_q;
    if (wdt_tick) begin
      post_d = post_q + 1'b1;
      if (&post_q) begin
        cnt_d = cnt_q + 1'b1;
      end
    end
    // a restart beats a tick in the same cycle
    if (wd_clear) begin
      cnt_d = '0;
      post_d = '0;
    end
  end

  // watchdog registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      post_q <= '0;
    end else if (clk_en) begin
      cnt_q <= cnt_d;
      post_q <= post_d;
    end
  end

  // ==========================================================
  // read data captured at the setup edge; a read whose setup edge
  // falls while frozen returns the word captured before
  always_comb begin
    rdata_d = rdata_q;
    if (rd_setup) begin
      // unmapped offsets read as zero
      unique case (paddr)
        clr_exec_pkg::instr_off: rdata_d = {15'h0000, pend_q, instr_q};
        clr_exec_pkg::ctrl_off: rdata_d = {31'h0, ext_q};
        clr_exec_pkg::bank_off: rdata_d = {28'h0, bank_select_register};
        clr_exec_pkg::fsr2_off: rdata_d = {20'h0, fsr2_q};
        clr_exec_pkg::status_off: rdata_d = {27'h0, status_q};
        clr_exec_pkg::wdt_off: rdata_d = 32'({post_q, cnt_q});
        clr_exec_pkg::wr_off: rdata_d = {done_q, 4'h0, addr_q};
        default: rdata_d = clr_exec_pkg::unmapped_rdata;
      endcase
    end
  end

  // read data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (clk_en) begin
      rdata_q <= rdata_d;
    end
  end

  // outputs straight from flops, except file_wdata, which is the constant clear_value
  assign watchdog_counter = cnt_q;
  assign wdt_post = post_q;
  assign timeout_status_n = status_q[clr_exec_pkg::timeout_pos];
  assign powerdown_status_n = status_q[clr_exec_pkg::powerdown_pos];
  assign file_we = we_q;
  assign file_addr = addr_q;
  assign file_wdata = clr_exec_pkg::clear_value;
  assign busy = pend_q;
endmodule

// ==== src/clr_exec_pkg.sv ====
// constants for the file-clear and watchdog-restart execution unit
package clr_exec_pkg;
  // ==========================================================
  // opcode patterns
  localparam logic [15:0] file_clear_mask = 16'hfe00;
  localparam logic [15:0] file_clear_code = 16'h6a00;
  localparam logic [15:0] watchdog_restart_code = 16'h0004;
  localparam int bank_bit_pos = 8;
  // ==========================================================
  // addressing
  localparam logic [7:0] indexed_limit = 8'h5f;
  localparam logic [7:0] access_split = 8'h60;
  localparam logic [3:0] access_high_bank = 4'hf;
  localparam logic [7:0] clear_value = 8'h00;
  // ==========================================================
  // register map (apb byte addresses)
  localparam logic [7:0] instr_off = 8'h00;
  localparam logic [7:0] ctrl_off = 8'h04;
  localparam logic [7:0] bank_off = 8'h08;
  localparam logic [7:0] fsr2_off = 8'h0c;
  localparam logic [7:0] status_off = 8'h10;
  localparam logic [7:0] wdt_off = 8'h14;
  localparam logic [7:0] wr_off = 8'h18;
  // ==========================================================
  // status bits and reset values
  localparam int zero_pos = 2;
  localparam int powerdown_pos = 3;
  localparam int timeout_pos = 4;
  localparam logic [4:0] status_rst = 5'h18;
  localparam logic [31:0] unmapped_rdata = 32'h0000_0000;
  // ==========================================================
  // four phase cycle
  typedef enum logic [1:0] {
    ph_decode = 2'b00,
    ph_read = 2'b01,
    ph_process = 2'b10,
    ph_write = 2'b11
  } phase_e;
endpackage

// ==== dv/clr_exec_assertions.sv ====
// checker for the file-clear and watchdog-restart unit
module clr_exec_assertions #(
  parameter int cnt_w = 16,
  parameter int post_w = 8
) (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pready,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  input logic busy,
  input logic file_we,
  input logic [11:0] file_addr,
  input logic [7:0] file_wdata,
  input logic [cnt_w-1:0] watchdog_counter,
  input logic [post_w-1:0] wdt_post,
  input logic timeout_status_n,
  input logic powerdown_status_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // accepted instruction writes; a write while busy is dropped
  logic go;
  logic fc;
  logic wr;
  assign go = psel && penable && pready && pwrite && paddr == 8'h00 && !busy;
  assign fc = go && pwdata[15:9] == 7'h35;
  assign wr = go && pwdata[15:0] == clr_exec_pkg::watchdog_restart_code;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // assertions
  we_pulse_a: assert property (file_we |=> !file_we)
    else $error("write strobe longer than one cycle");
  busy_len_a: assert property ($rose(busy) |-> busy[*4] ##1 !busy)
    else $error("instruction not four cycles long");
  clr_data_a: assert property (file_we |-> file_wdata == 8'h00)
    else $error("cleared register not written with zero");
  clr_when_a: assert property (fc |-> ##1 !file_we[*4] ##1 file_we)
    else $error("clear strobe not in write phase");
  bank_one_a: assert property (fc && pwdata[8] |->
    ##5 file_addr[7:0] == $past(pwdata[7:0], 5))
    else $error("banked address lost file field");
  acc_high_a: assert property (fc && !pwdata[8] &&
    pwdata[7:0] > 8'h5f |-> ##5 file_addr == {4'hf, $past(pwdata[7:0], 5)})
    else $error("access bank upper half wrong");
  cnt_zero_a: assert property (wr |-> ##4 watchdog_counter == '0)
    else $error("watchdog counter not cleared");
  post_zero_a: assert property (wr |-> ##4 wdt_post == '0)
    else $error("postscaler not cleared");
  stat_set_a: assert property (wr |-> ##4
    timeout_status_n && powerdown_status_n)
    else $error("status bits not set by restart");
  // main scenarios reached
  cover property (fc && pwdata[8]);
  cover property (fc && !pwdata[8]);
  cover property (wr);
endmodule

// ==== dv/tb_top.sv ====
// self-checking bench for the file-clear and watchdog-restart unit
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, wdt_tick = 1'b0, pready, busy, file_we;
  logic clk_en = 1'b1, t;
  logic timeout_status_n, powerdown_status_n;
  logic [7:0] paddr = 8'h00, file_wdata;
  logic [31:0] pwdata = 32'h0, prdata, r, v;
  logic [15:0] watchdog_counter;
  logic [3:0] wdt_post;
  logic [11:0] file_addr;
  logic [11:0] q[$];
  int failures, checked, seed, n;
  // short postscaler so the counter moves within a short run
  clr_exec #(.post_w(4)) i_dut (.pclk, .presetn, .clk_en, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr(),
    .wdt_tick, .watchdog_counter, .wdt_post, .timeout_status_n,
    .powerdown_status_n, .file_we, .file_addr, .file_wdata, .busy);
  initial forever #20 pclk = ~pclk;
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    checked++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  // ==========================================================
  // apb master: request held until pready is seen high
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic ins(logic [15:0] op);
    apb(1'b1, 8'h00, {16'h0, op});
    do @(posedge pclk); while (busy !== 1'b0);
  endtask
  task automatic give_verdict;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================================
  // monitor: every write strobe must match the oldest expectation
  always @(posedge pclk)
    if (file_we === 1'b1) begin
      chk("clear data", 32'h0, {24'h0, file_wdata});
      if (q.size() == 0) chk("extra write", 32'h0, 32'h1);
      else chk("file addr", {20'h0, q.pop_front()},
        {20'h0, file_addr});
    end
  initial begin
    repeat (5000) @(posedge pclk);
    failures++;
    give_verdict();
  end
  initial begin
    seed = 27;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h10, 32'h0);
    chk("status rst", 32'h18, r);
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped", 32'h0, r);
    apb(1'b1, 8'h08, 32'h3);
    apb(1'b1, 8'h10, 32'h0);
    q.push_back(12'h305);
    ins(16'h6b05);
    apb(1'b0, 8'h10, 32'h0);
    chk("zero flag", 32'h04, r);
    repeat (4) begin
      v = $random(seed);
      apb(1'b1, 8'h08, {28'h0, v[11:8]});
      q.push_back(v[11:0]);
      ins({7'h35, 1'b1, v[7:0]});
    end
    // low half of the access bank while extended mode is off
    q.push_back(12'h020);
    ins(16'h6a20);
    // upper half of the access bank while extended mode is off
    q.push_back(12'hfff);
    ins(16'h6aff);
    apb(1'b1, 8'h04, 32'h1);
    apb(1'b1, 8'h0c, 32'h100);
    q.push_back(12'h15f);
    ins(16'h6a5f);
    q.push_back(12'hf60);
    ins(16'h6a60);
    // the bank bit wins over the indexed window
    q.push_back({v[11:8], 8'h30});
    ins(16'h6b30);
    // second write lands while busy and must be dropped
    q.push_back(12'h110);
    apb(1'b1, 8'h00, 32'h6a10);
    ins(16'h6a11);
    // ticks while clk_en is low must not count
    clk_en <= 1'b0;
    wdt_tick <= 1'b1;
    repeat (8) @(posedge pclk);
    clk_en <= 1'b1;
    wdt_tick <= 1'b0;
    repeat (100) begin
      @(posedge pclk);
      t = 1'($random(seed));
      wdt_tick <= t;
      n += t;
    end
    @(posedge pclk);
    wdt_tick <= 1'b0;
    apb(1'b0, 8'h14, 32'h0);
    chk("watchdog", {12'h0, 4'(n), 16'(n >> 4)}, r);
    apb(1'b1, 8'h10, 32'h0);
    ins(16'h0004);
    chk("counter", 32'h0, {16'h0, watchdog_counter});
    chk("postscaler", 32'h0, {28'h0, wdt_post});
    apb(1'b0, 8'h10, 32'h0);
    chk("status set", 32'h18, r);
    chk("pending", 32'h0, q.size());
    give_verdict();
  end
endmodule
bind clr_exec clr_exec_assertions #(.cnt_w(cnt_w), .post_w(post_w)) i_chk (
  .pclk, .presetn, .psel, .penable, .pready, .pwrite, .paddr, .pwdata, .busy,
  .file_we, .file_addr, .file_wdata, .watchdog_counter, .wdt_post,
  .timeout_status_n, .powerdown_status_n);
